/* hdl/cbr_branch.sv */
// Decode and execute logic for the two conditional relative branches.
// Assumes the core supplies the opcode word, the address of the instruction, the
// status flags, and a one-cycle pulse at the start of each instruction cycle.
//
// How it works
// - Upper byte e5 branches only while the overflow flag is clear.
// - Upper byte e1 branches only while the zero flag is clear.
// - Low byte is a signed offset, doubled, so targets stay on even addresses.
// - Target is instruction address plus two plus doubled offset.
// - One cycle when not taken; taken adds a second, empty cycle.
`timescale 1ns/1ns

module cbr_branch (
  // Clock and reset.
  input  wire logic                      i_mclk,
  input  wire logic                      i_rst_n,
  // Instruction in flight.
  input  wire logic                      i_cycle_start,
  input  wire logic [cbr_pkg::OPC_W-1:0] i_opcode,
  input  wire logic [cbr_pkg::PC_W-1:0]  i_instr_addr,
  input  wire cbr_pkg::cbr_flags_t       i_flags,
  // Results to the core.
  output logic                           o_is_branch,
  output cbr_pkg::cbr_pc_wr_t            o_pc_wr,
  output logic                           o_flush,
  output logic                           o_busy,
  output cbr_pkg::cbr_phase_t            o_phase
);

  // Literal width, upper-byte width and the shift that doubles the offset.
  localparam int LIT_W    = cbr_pkg::OFFSET_MSB + 1;
  localparam int OPC_HI_W = cbr_pkg::OPC_W - cbr_pkg::OPC_HI_LSB;
  localparam int DBL_SH   = 1;

  // Execution states of one branch instruction.
  typedef enum logic [1:0] {
    CBR_IDLE,
    CBR_EXEC,
    CBR_NOP
  } cbr_state_t;

  // Sequencer state: where the instruction stands and which phase runs.
  cbr_state_t                    state_reg;
  cbr_state_t                    state_next;
  cbr_pkg::cbr_phase_t           phase_reg;
  cbr_pkg::cbr_phase_t           phase_next;
  // Outcome of the decode, held for the whole instruction.
  logic                          take_reg;
  logic                          take_next;
  logic                          isbr_reg;
  logic                          isbr_next;
  // Literal captured from the opcode and the branch target built from it.
  logic [LIT_W-1:0]              lit_reg;
  logic [LIT_W-1:0]              lit_next;
  logic [cbr_pkg::PC_W-1:0]      target_reg;
  logic [cbr_pkg::PC_W-1:0]      target_next;
  // Program counter write request and the matching flush.
  cbr_pkg::cbr_pc_wr_t           pcw_reg;
  cbr_pkg::cbr_pc_wr_t           pcw_next;
  logic                          flush_reg;
  logic                          flush_next;
  // Combinational decode terms.
  logic [OPC_HI_W-1:0]           opc_hi;
  logic                          dec_nov;
  logic                          dec_nz;
  logic                          dec_any;
  logic                          start;
  logic                          in_exec;
  wire logic [cbr_pkg::PC_W-1:0] offs2;

  // Decode of the upper opcode byte; only the two branch codes start execution.
  // Any other code leaves the block at rest, so the rest of the core handles it alone.
  assign opc_hi  = i_opcode[cbr_pkg::OPC_HI_LSB +: OPC_HI_W];
  assign dec_nov = (opc_hi == cbr_pkg::OPC_BRANCH_IF_NO_OVERFLOW);
  assign dec_nz  = (opc_hi == cbr_pkg::OPC_BRANCH_IF_NONZERO);
  assign dec_any = dec_nov | dec_nz;

  // A start pulse counts only while no branch is in flight.
  // A pulse that arrives during a branch is dropped without notice; the core must not send one.
  assign start   = i_cycle_start & (state_reg == CBR_IDLE);
  assign in_exec = (state_reg == CBR_EXEC);

  // Doubled, sign-extended offset, built one bit at a time; the lowest bit is always clear.
  for (genvar gi = 0; gi < cbr_pkg::PC_W; gi++) begin : g_offs
    if (gi < DBL_SH) begin : g_even
      assign offs2[gi] = 1'b0;
    end else if (gi < LIT_W + DBL_SH) begin : g_lit
      assign offs2[gi] = lit_reg[gi-DBL_SH];
    end else begin : g_sign
      assign offs2[gi] = lit_reg[cbr_pkg::OFFSET_MSB];
    end
  end

  // Sequencer: an accepted branch runs four phases, then four empty ones if it was taken.
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    if (state_reg != CBR_IDLE) begin
      // Phases step from Q1 to Q4 once per clock and wrap into the next cycle.
      phase_next = cbr_pkg::cbr_phase_t'(phase_reg + 2'h1);
    end
    case (state_reg)
      CBR_IDLE: begin
        if (start) begin
          phase_next = cbr_pkg::CBR_Q1;
          if (dec_any) begin
            state_next = CBR_EXEC;
          end
        end
      end
      CBR_EXEC: begin
        if (phase_reg == cbr_pkg::CBR_Q4) begin
          // A taken branch owes one more cycle that does nothing.
          state_next = take_reg ? CBR_NOP : CBR_IDLE;
        end
      end
      CBR_NOP: begin
        // The second cycle of a taken branch performs no operation.
        if (phase_reg == cbr_pkg::CBR_Q4) begin
          state_next = CBR_IDLE;
        end
      end
      default: begin
        state_next = CBR_IDLE;
      end
    endcase
  end

  // Sequencer registers.
  // Reset parks the block at rest in phase Q1, ready for a start at the first edge.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= CBR_IDLE;
      phase_reg <= cbr_pkg::CBR_Q1;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
    end
  end

  // Condition: sampled once at decode, so a flag change later in the cycle has no effect.
  // The flags are only read here; this block never writes them.
  always_comb begin
    take_next = take_reg;
    isbr_next = isbr_reg;
    if (start) begin
      isbr_next = dec_any;
      take_next = (dec_nov & ~i_flags.overflow) | (dec_nz & ~i_flags.zero);
    end else if ((state_reg == CBR_NOP) && (phase_reg == cbr_pkg::CBR_Q4)) begin
      // The taken branch is retired at the end of its empty cycle.
      take_next = 1'b0;
      isbr_next = 1'b0;
    end
  end

  // Condition registers.
  // Both clear in reset, so no branch is pending when the core comes out of it.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      take_reg <= 1'b0;
      isbr_reg <= 1'b0;
    end else begin
      take_reg <= take_next;
      isbr_reg <= isbr_next;
    end
  end

  // Literal and target: the literal is read in Q1, the target is formed in Q2.
  // The literal is taken one clock after decode, so the opcode must still stand then.
  always_comb begin
    lit_next    = lit_reg;
    target_next = target_reg;
    if (in_exec && (phase_reg == cbr_pkg::CBR_Q1)) begin
      lit_next = i_opcode[cbr_pkg::OFFSET_MSB:0];
    end
    if (in_exec && (phase_reg == cbr_pkg::CBR_Q2)) begin
      // The counter has already moved past this word, hence the step of two; the sum wraps.
      target_next = i_instr_addr + cbr_pkg::PC_STEP + offs2;
    end
  end

  // Literal and target registers.
  // They keep their last values between branches; only a new branch reads them.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lit_reg    <= '0;
      target_reg <= '0;
    end else begin
      lit_reg    <= lit_next;
      target_reg <= target_next;
    end
  end

  // Program counter write: prepared in Q3 so that it stands during Q4, only when taken.
  // The flush travels with the write, so the word already fetched is thrown away.
  always_comb begin
    pcw_next   = '0;
    flush_next = 1'b0;
    if (in_exec && (phase_reg == cbr_pkg::CBR_Q3)) begin
      pcw_next.we    = take_reg;
      pcw_next.value = target_reg;
      flush_next     = take_reg;
    end
  end

  // Program counter write and flush registers.
  // Each is a one-clock pulse; both clear in reset so no stray write leaves the block.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pcw_reg   <= '0;
      flush_reg <= 1'b0;
    end else begin
      pcw_reg   <= pcw_next;
      flush_reg <= flush_next;
    end
  end

  // Outputs.
  assign o_is_branch = isbr_reg;
  assign o_pc_wr     = pcw_reg;
  assign o_flush     = flush_reg;
  assign o_busy      = (state_reg != CBR_IDLE);
  assign o_phase     = phase_reg;

endmodule

/* hdl/cbr_pkg.sv */
// Package for the conditional relative-branch decode and execute block.
// Assumes a byte-addressed program counter and a four-phase instruction cycle.
package cbr_pkg;

  // Widths.
  localparam int OPC_W = 16;
  localparam int PC_W  = 21;

  // Upper-byte opcodes of the two branches.
  localparam logic [7:0] OPC_BRANCH_IF_NO_OVERFLOW = 8'he5;
  localparam logic [7:0] OPC_BRANCH_IF_NONZERO     = 8'he1;

  // Field positions inside the opcode word.
  localparam int OPC_HI_LSB  = 8;
  localparam int OFFSET_MSB  = 7;

  // Increment applied to the fetch address of the branch.
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

  // Phase numbering within one instruction cycle.
  typedef enum logic [1:0] {
    CBR_Q1,
    CBR_Q2,
    CBR_Q3,
    CBR_Q4
  } cbr_phase_t;

  // Flags the block reads; it never writes them.
  typedef struct packed {
    logic overflow;
    logic zero;
  } cbr_flags_t;

  // Program counter write request.
  typedef struct packed {
    logic            we;
    logic [PC_W-1:0] value;
  } cbr_pc_wr_t;

endpackage

/* tb/cbr_branch_bench.sv */
// Bench for the branch block: both branches taken, untaken, and another opcode.
// Assumes the package and design are compiled first.
`timescale 1ns/1ns
module cbr_branch_bench;
  logic                i_mclk = 0, i_rst_n = 0, i_cycle_start = 0;
  logic [15:0]         i_opcode = '0;
  logic [20:0]         i_instr_addr = '0;
  cbr_pkg::cbr_flags_t i_flags = '0;
  logic                o_is_branch, o_flush, o_busy;
  cbr_pkg::cbr_pc_wr_t o_pc_wr;
  cbr_pkg::cbr_phase_t o_phase;
  int                  n_errors = 0, checked = 0, cyc = 0;
  cbr_branch dut (.*);
  always #10 i_mclk = ~i_mclk;
  // Cuts a hung run short.
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors = n_errors + 1;
      give_verdict();
    end
  end
  // Compares one result.
  task automatic chk(string nm, logic [21:0] e, logic [21:0] g);
    checked++;
    if (e !== g) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Issues one instruction, then checks its decode, phases, pc write, flush and busy length.
  task automatic run(logic [15:0] op, logic [20:0] a, logic [1:0] f, logic [21:0] ev, int eb, logic ib);
    int          nb;
    int          nf;
    logic [21:0] wv;
    nb = 0;
    nf = 0;
    wv = '0;
    @(negedge i_mclk);
    {i_cycle_start, i_opcode, i_instr_addr, i_flags} <= {1'b1, op, a, f};
    @(negedge i_mclk);
    i_cycle_start <= 1'b0;
    chk("is branch", 22'(ib), 22'(o_is_branch));
    for (int j = 0; j < 10; j++) begin
      if (o_busy === 1'b1) begin
        nb++;
        chk("phase", 22'(j % 4), 22'(o_phase));
      end
      if (o_flush === 1'b1) nf++;
      if (o_pc_wr.we === 1'b1) wv = o_pc_wr;
      @(negedge i_mclk);
    end
    chk("pc write", ev, wv);
    chk("flush pulses", 22'(ev[21]), 22'(nf));
    chk("busy cycles", 22'(eb), 22'(nb));
  endtask
  // Overflow clear: taken with the most negative offset.
  task automatic scen_nov_taken();
    run(16'he580, 21'h001000, 2'b00, 22'h200f02, 8, 1'b1);
  endtask
  // Overflow set: falls through in one cycle.
  task automatic scen_nov_untaken();
    run(16'he57f, 21'h001000, 2'b10, 22'h000000, 4, 1'b1);
  endtask
  // Zero clear: taken, target wraps past the top of the address space.
  task automatic scen_nz_taken();
    run(16'he17f, 21'h1ffffe, 2'b10, 22'h2000fe, 8, 1'b1);
  endtask
  // Zero set: falls through in one cycle.
  task automatic scen_nz_untaken();
    run(16'he101, 21'h000200, 2'b01, 22'h000000, 4, 1'b1);
  endtask
  // Another opcode: the block stays at rest.
  task automatic scen_other_op();
    run(16'he310, 21'h000200, 2'b00, 22'h000000, 0, 1'b0);
  endtask
  // Reset in mid-branch: everything returns to rest and no write appears afterwards.
  task automatic scen_reset_mid();
    int nw;
    nw = 0;
    @(negedge i_mclk);
    {i_cycle_start, i_opcode, i_instr_addr, i_flags} <= {1'b1, 16'he104, 21'h000100, 2'b00};
    @(negedge i_mclk);
    i_cycle_start <= 1'b0;
    @(negedge i_mclk);
    i_rst_n <= 1'b0;
    @(negedge i_mclk);
    chk("busy in reset", 22'h0, 22'(o_busy));
    chk("pc write in reset", 22'h0, 22'(o_pc_wr));
    i_rst_n <= 1'b1;
    repeat (10) begin
      if (o_pc_wr.we === 1'b1) nw++;
      @(negedge i_mclk);
    end
    chk("pc writes after reset", 22'h0, 22'(nw));
    chk("busy after reset", 22'h0, 22'(o_busy));
  endtask
  // Prints the counts and the verdict.
  task automatic give_verdict();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence, instructions one after another with idle clocks between.
  initial begin
    repeat (6) @(negedge i_mclk);
    i_rst_n <= 1'b1;
    scen_nov_taken();
    scen_nov_untaken();
    scen_nz_taken();
    scen_nz_untaken();
    scen_reset_mid();
    scen_other_op();
    give_verdict();
  end
endmodule

/* tb/cbr_chk.sv */
// Port checker for the conditional branch block.
// Assumes it is bound onto cbr_branch and sees only its ports.
`timescale 1ns/1ns
module cbr_chk (
  input wire logic                      i_mclk,
  input wire logic                      i_rst_n,
  input wire logic                      i_cycle_start,
  input wire logic [cbr_pkg::OPC_W-1:0] i_opcode,
  input wire logic [cbr_pkg::PC_W-1:0]  i_instr_addr,
  input wire cbr_pkg::cbr_flags_t       i_flags,
  input wire logic                      o_is_branch,
  input wire cbr_pkg::cbr_pc_wr_t       o_pc_wr,
  input wire logic                      o_flush,
  input wire logic                      o_busy,
  input wire cbr_pkg::cbr_phase_t       o_phase
);
  // Start, opcode class and flag outcome at the taking edge.
  wire logic ov = i_opcode[15:8] == cbr_pkg::OPC_BRANCH_IF_NO_OVERFLOW;
  wire logic nz = i_opcode[15:8] == cbr_pkg::OPC_BRANCH_IF_NONZERO;
  wire logic st = i_cycle_start && !o_busy;
  wire logic go = st && (ov && !i_flags.overflow || nz && !i_flags.zero);
  wire logic stay = st && (ov && i_flags.overflow || nz && i_flags.zero);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // The empty second cycle of a taken branch.
  sequence s_nop;
    (o_busy && !o_pc_wr.we)[*4];
  endsequence
  a_taken_target: assert property (go |-> ##4 o_pc_wr.we && o_pc_wr.value == $past(i_instr_addr, 4)
    + cbr_pkg::PC_STEP + 21'({{12{$past(i_opcode[7], 4)}}, $past(i_opcode[7:0], 4), 1'b0})
    ##1 s_nop ##1 !o_busy) else $error("taken branch wrong");
  a_not_taken: assert property (stay |-> ##1 (o_busy && !o_pc_wr.we)[*4] ##1 !o_busy)
    else $error("untaken branch wrong");
  a_other_ignored: assert property (st && !ov && !nz |=> !o_busy) else $error("other opcode run");
  a_flush_pair: assert property (o_pc_wr.we == o_flush) else $error("flush apart from pc write");
  a_write_in_q4: assert property (o_pc_wr.we |-> o_phase == cbr_pkg::CBR_Q4 && o_is_branch)
    else $error("pc write outside q4");
  a_phase_order: assert property (go |=> o_phase == cbr_pkg::CBR_Q1 ##1 o_phase == cbr_pkg::CBR_Q2)
    else $error("phase order wrong");
endmodule

bind cbr_branch cbr_chk u_chk (.*);
